// ### psc_ctrl.sv
`timescale 1ns/1ps
module psc_ctrl #(
    parameter int IRQS = 64
) (
    input  wire logic            core_clk,
    input  wire logic            rst,
    input  wire logic [31:0]     cpu_addr,
    input  wire logic            cpu_wr,
    input  wire logic            cpu_rd,
    input  wire logic            cpu_bit_op,
    input  wire logic [1:0]      cpu_bit_kind,
    input  wire logic [2:0]      cpu_bit_sel,
    input  wire logic [7:0]      cpu_wdata,
    input  wire logic            cpu_instr_done,
    input  wire logic            nmi_pin_0,
    input  wire logic            nmi_pin_1,
    input  wire logic            nmi_pin_2,
    input  wire logic [IRQS-1:0] maskable_irq_inputs,
    input  wire logic [IRQS-1:0] irq_service_en,
    output logic      [7:0]      cpu_rdata_r,
    output logic                 cpu_rd_valid_r,
    output logic                 irq_ack_inhibit_r,
    output logic                 write_rejected_r,
    output logic                 soft_stop_active_r,
    output logic                 cpu_clk_stop_r,
    output logic                 clk_gen_stop_r,
    output logic                 periph_halt_r
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [31:0] a,
                                 input logic [31:0] target);
        hit = (a == target);
    endfunction : hit

    function automatic logic [7:0] bit_modify(input logic [7:0] cur,
                                              input logic [1:0] kind,
                                              input logic [2:0] sel);
        logic [7:0] onehot;
        onehot = 8'h01 << sel;
        case (kind)
            psc_pkg::BITOP_SET:    bit_modify = cur | onehot;
            psc_pkg::BITOP_CLEAR:  bit_modify = cur & ~onehot;
            psc_pkg::BITOP_INVERT: bit_modify = cur ^ onehot;
            default:               bit_modify = cur;
        endcase
    endfunction : bit_modify

    logic unlock_wr;
    logic ctrl_wr;
    logic ctrl_rd;
    logic unlock_rd;

    // the unlock register ignores single bit operations
    assign unlock_wr = cpu_wr && !cpu_bit_op
                       && hit(cpu_addr, psc_pkg::UNLOCK_ADDR);
    assign ctrl_wr   = cpu_wr && hit(cpu_addr, psc_pkg::CONTROL_ADDR);
    assign ctrl_rd   = cpu_rd && hit(cpu_addr, psc_pkg::CONTROL_ADDR);
    assign unlock_rd = cpu_rd && hit(cpu_addr, psc_pkg::UNLOCK_ADDR);

    // ------------------------------------------------------------
    // request inputs
    // ------------------------------------------------------------
    logic [2:0]      nmi_sync;
    logic [IRQS-1:0] irq_sync;
    logic            wake_r;

    psc_sync #(.WIDTH(3)) u_nmi_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in ({nmi_pin_2, nmi_pin_1, nmi_pin_0}),
        .sync_out (nmi_sync)
    );

    psc_sync #(.WIDTH(IRQS)) u_irq_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (maskable_irq_inputs),
        .sync_out (irq_sync)
    );

    logic [7:0] psc_r;
    logic [7:0] psc_nxt;

    psc_wake #(.IRQS(IRQS)) u_wake (
        .core_clk       (core_clk),
        .rst            (rst),
        .nmi_req        (nmi_sync),
        .nmi_mask       ({psc_r[psc_pkg::NMI_LINE2_REQUEST_MASK_POS],
                          psc_r[psc_pkg::NMI_LINE1_REQUEST_MASK_POS],
                          psc_r[psc_pkg::NMI_LINE0_REQUEST_MASK_POS]}),
        .irq_req        (irq_sync),
        .irq_mask       (psc_r[psc_pkg::IRQ_MASK_POS]),
        .irq_service_en (irq_service_en),
        .wake_r         (wake_r)
    );

    // ------------------------------------------------------------
    // unlock and control register
    // ------------------------------------------------------------
    psc_pkg::psc_state_type state_r;
    psc_pkg::psc_state_type state_nxt;

    logic       unlock_r;
    logic       unlock_nxt;
    logic       rejected_nxt;
    logic [7:0] wval;

    always_comb begin
        unlock_nxt   = unlock_r;
        rejected_nxt = 1'b0;
        psc_nxt      = psc_r;
        wval         = cpu_bit_op ? bit_modify(psc_r, cpu_bit_kind,
                                               cpu_bit_sel)
                                  : cpu_wdata;
        if (unlock_wr) begin
            unlock_nxt = 1'b1;
        end else if (ctrl_wr) begin
            unlock_nxt = 1'b0;
        end else if (cpu_instr_done) begin
            // a stray instruction between the pair drops the key
            unlock_nxt = 1'b0;
        end
        if (ctrl_wr && unlock_r) begin
            psc_nxt = wval & psc_pkg::WRITABLE_BITS;
            if (wval[psc_pkg::STOP_REQ_POS]) begin
                psc_nxt = (psc_nxt & ~psc_pkg::MASK_BITS)
                          | (psc_r & psc_pkg::MASK_BITS);
            end
        end else if (ctrl_wr) begin
            rejected_nxt = 1'b1;
        end
        if (state_r == psc_pkg::ST_STOP && wake_r) begin
            psc_nxt[psc_pkg::STOP_REQ_POS] = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            psc_r            <= psc_pkg::CONTROL_RESET;
            unlock_r         <= 1'b0;
            write_rejected_r <= 1'b0;
        end else begin
            psc_r            <= psc_nxt;
            unlock_r         <= unlock_nxt;
            write_rejected_r <= rejected_nxt;
        end
    end

    // ------------------------------------------------------------
    // stop sequencing
    // ------------------------------------------------------------
    logic inhibit_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            psc_pkg::ST_RUN: begin
                if (psc_r[psc_pkg::STOP_REQ_POS]) begin
                    state_nxt = psc_pkg::ST_STOP;
                end
            end
            psc_pkg::ST_STOP: begin
                if (wake_r) begin
                    state_nxt = psc_pkg::ST_RUN;
                end
            end
            default: state_nxt = psc_pkg::ST_RUN;
        endcase
        // the core must not take an interrupt on the unlock store
        inhibit_nxt = unlock_nxt;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r            <= psc_pkg::ST_RUN;
            soft_stop_active_r <= 1'b0;
            cpu_clk_stop_r     <= 1'b0;
            clk_gen_stop_r     <= 1'b0;
            periph_halt_r      <= 1'b0;
            irq_ack_inhibit_r  <= 1'b0;
        end else begin
            state_r            <= state_nxt;
            soft_stop_active_r <= (state_nxt == psc_pkg::ST_STOP);
            cpu_clk_stop_r     <= (state_nxt == psc_pkg::ST_STOP);
            clk_gen_stop_r     <= (state_nxt == psc_pkg::ST_STOP);
            periph_halt_r      <= (state_nxt == psc_pkg::ST_STOP);
            irq_ack_inhibit_r  <= inhibit_nxt;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] rdata_nxt;
    logic       rd_valid_nxt;

    always_comb begin
        rdata_nxt    = 8'h00;
        rd_valid_nxt = 1'b0;
        if (ctrl_rd) begin
            rdata_nxt    = psc_r;
            rd_valid_nxt = 1'b1;
        end else if (unlock_rd) begin
            rdata_nxt    = psc_pkg::UNLOCK_READ;
            rd_valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cpu_rdata_r    <= 8'h00;
            cpu_rd_valid_r <= 1'b0;
        end else begin
            cpu_rdata_r    <= rdata_nxt;
            cpu_rd_valid_r <= rd_valid_nxt;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    reset_value_a: assert property (
        $fell(rst) |-> psc_r == psc_pkg::CONTROL_RESET && !unlock_r
            && state_r == psc_pkg::ST_RUN)
        else $error("control register not clear after reset");

    reserved_idle_a: assert property (
        (psc_r & ~psc_pkg::WRITABLE_BITS) == 8'h00)
        else $error("reserved control bits not zero");

    reserved_zero_a: assert property (
        (ctrl_wr && unlock_r) |=>
            (psc_r & ~psc_pkg::WRITABLE_BITS) == 8'h00)
        else $error("reserved bit took a write");

    stop_enter_a: assert property (
        (ctrl_wr && unlock_r && wval[psc_pkg::STOP_REQ_POS]
         && state_r == psc_pkg::ST_RUN)
        |=> psc_r[psc_pkg::STOP_REQ_POS] ##1 soft_stop_active_r
            && cpu_clk_stop_r && clk_gen_stop_r && periph_halt_r)
        else $error("stop request did not enter stop");

    stop_clear_a: assert property (
        (state_r == psc_pkg::ST_STOP && wake_r)
        |=> !psc_r[psc_pkg::STOP_REQ_POS]
            && state_r == psc_pkg::ST_RUN ##1 !soft_stop_active_r)
        else $error("stop exit did not clear request");

    masked_hold_a: assert property (
        (state_r == psc_pkg::ST_STOP
         && (psc_r & psc_pkg::MASK_BITS) == psc_pkg::MASK_BITS)
        |=> state_r == psc_pkg::ST_STOP)
        else $error("fully masked stop was left");

    mask_ignore_a: assert property (
        (ctrl_wr && unlock_r && wval[psc_pkg::STOP_REQ_POS])
        |=> (psc_r & psc_pkg::MASK_BITS)
            == ($past(psc_r) & psc_pkg::MASK_BITS))
        else $error("masks changed with stop request");

    reject_write_a: assert property (
        (ctrl_wr && !unlock_r && state_r == psc_pkg::ST_RUN)
        |=> psc_r == $past(psc_r) && write_rejected_r)
        else $error("locked control write took effect");

    unlock_once_a: assert property (
        ctrl_wr |=> !unlock_r)
        else $error("unlock survived a control write");

    unlock_arm_a: assert property (
        unlock_wr |=> unlock_r && irq_ack_inhibit_r)
        else $error("unlock write did not arm");

    unlock_byte_a: assert property (
        (cpu_wr && cpu_bit_op && !unlock_r && !ctrl_wr) |=> !unlock_r)
        else $error("bit operation armed unlock");

    read_direct_a: assert property (
        ctrl_rd |=> cpu_rd_valid_r && cpu_rdata_r == $past(psc_r))
        else $error("control read returned wrong data");

    accept_write_a: assert property (
        (ctrl_wr && unlock_r && !cpu_bit_op
         && !cpu_wdata[psc_pkg::STOP_REQ_POS])
        |=> psc_r == ($past(cpu_wdata) & psc_pkg::WRITABLE_BITS)
            && !write_rejected_r)
        else $error("unlocked control write was lost");

    gap_disarm_a: assert property (
        (unlock_r && cpu_instr_done && !unlock_wr && !ctrl_wr)
        |=> !unlock_r)
        else $error("stray instruction kept the unlock");

    inhibit_drop_a: assert property (
        (unlock_r && cpu_instr_done && !unlock_wr)
        |=> !irq_ack_inhibit_r)
        else $error("interrupt inhibit outlived the unlock");

    // stop bit held low so the mask freeze on stop entry stays out
    bitop_set_a: assert property (
        (ctrl_wr && unlock_r && cpu_bit_op && cpu_bit_sel[2]
         && !psc_r[psc_pkg::STOP_REQ_POS]
         && cpu_bit_kind == psc_pkg::BITOP_SET)
        |=> psc_r[$past(cpu_bit_sel)])
        else $error("bit set did not land");

    bitop_clear_a: assert property (
        (ctrl_wr && unlock_r && cpu_bit_op && cpu_bit_sel[2]
         && !psc_r[psc_pkg::STOP_REQ_POS]
         && cpu_bit_kind == psc_pkg::BITOP_CLEAR)
        |=> !psc_r[$past(cpu_bit_sel)])
        else $error("bit clear did not land");

    nmi_line2_request_wake_a: assert property (
        (nmi_sync[2] && !psc_r[psc_pkg::NMI_LINE2_REQUEST_MASK_POS]) |=> wake_r)
        else $error("permitted nmi line 2 did not wake");

    nmi_line1_request_wake_a: assert property (
        (nmi_sync[1] && !psc_r[psc_pkg::NMI_LINE1_REQUEST_MASK_POS]) |=> wake_r)
        else $error("permitted nmi line 1 did not wake");

    nmi_line0_request_wake_a: assert property (
        (nmi_sync[0] && !psc_r[psc_pkg::NMI_LINE0_REQUEST_MASK_POS]) |=> wake_r)
        else $error("permitted nmi line 0 did not wake");

    irq_wake_a: assert property (
        (|(irq_sync & irq_service_en) && !psc_r[psc_pkg::IRQ_MASK_POS])
        |=> wake_r)
        else $error("permitted interrupt did not wake");

    masked_quiet_a: assert property (
        ((psc_r & psc_pkg::MASK_BITS) == psc_pkg::MASK_BITS) |=> !wake_r)
        else $error("masked request raised a wake");

    stop_outputs_a: assert property (
        (soft_stop_active_r == (state_r == psc_pkg::ST_STOP))
        && cpu_clk_stop_r == soft_stop_active_r
        && clk_gen_stop_r == soft_stop_active_r
        && periph_halt_r == soft_stop_active_r)
        else $error("stop outputs disagree with the state");

    accepted_cv: cover property (
        unlock_wr ##1 (ctrl_wr && unlock_r));
    stop_cycle_cv: cover property (
        (state_r == psc_pkg::ST_RUN) ##1 (state_r == psc_pkg::ST_STOP)
        ##[1:20] (state_r == psc_pkg::ST_RUN));
    rejected_cv: cover property (ctrl_wr && !unlock_r);
    bitop_cv: cover property (ctrl_wr && unlock_r && cpu_bit_op);
    wake_cv: cover property ((state_r == psc_pkg::ST_STOP) && wake_r);
endmodule : psc_ctrl

// ### psc_pkg.sv
// What this block does
// - power save control is an 8-bit register, reset value zero.
// - writing one to the stop request bit asks for software stop.
// - hardware clears the stop request bit when software stop ends.
// - bit 7 masks nmi line 2; one prohibits, zero permits.
// - bit 6 masks nmi line 1; one prohibits, zero permits.
// - bit 5 masks nmi line 0; one prohibits, zero permits.
// - bit 4 masks all 64 maskable interrupt inputs.
// - masked requests are dropped, never held pending, cannot end stop.
// - mask bits written together with stop request are ignored.
// - permitted request ends stop unless irq mask registers block it.
// - control register takes whole byte and single bit accesses.
// - only the first control write after an unlock write is accepted.
// - any byte value written to the unlock register unlocks.
// - unlock register takes byte writes only; its read is undefined.
// - no interrupt is acknowledged on the unlock store.
// - control register reads need no unlock step.
// - in stop, cpu clock, clock generator and peripherals halt.
// - reset ends stop and acts as a normal reset.
package psc_pkg;
    localparam logic [31:0] UNLOCK_ADDR    = 32'hFFFFF1FC;
    localparam logic [31:0] CONTROL_ADDR   = 32'hFFFFF1FE;
    localparam logic [7:0]  CONTROL_RESET  = 8'h00;
    localparam logic [7:0]  WRITABLE_BITS  = 8'hF2;
    localparam logic [7:0]  MASK_BITS      = 8'hF0;
    localparam logic [7:0]  UNLOCK_READ    = 8'h00;
    localparam int          NMI_LINE2_REQUEST_MASK_POS  = 7;
    localparam int          NMI_LINE1_REQUEST_MASK_POS  = 6;
    localparam int          NMI_LINE0_REQUEST_MASK_POS  = 5;
    localparam int          IRQ_MASK_POS   = 4;
    localparam int          STOP_REQ_POS   = 1;
    localparam int          IRQ_COUNT      = 64;
    localparam int          NMI_COUNT      = 3;
    localparam logic [1:0]  BITOP_SET      = 2'h0;
    localparam logic [1:0]  BITOP_CLEAR    = 2'h1;
    localparam logic [1:0]  BITOP_INVERT   = 2'h2;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_STOP = 2'b10
    } psc_state_type;
endpackage : psc_pkg

// ### psc_sync.sv
`timescale 1ns/1ps
module psc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    // first stage is read only by the second stage
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : psc_sync

// ### psc_wake.sv
`timescale 1ns/1ps
module psc_wake #(
    parameter int IRQS = 64
) (
    input  wire logic            core_clk,
    input  wire logic            rst,
    input  wire logic [2:0]      nmi_req,
    input  wire logic [2:0]      nmi_mask,
    input  wire logic [IRQS-1:0] irq_req,
    input  wire logic            irq_mask,
    input  wire logic [IRQS-1:0] irq_service_en,
    output logic                 wake_r
);
    logic wake_nxt;

    // plain level gating: a masked request leaves no trace behind
    always_comb begin
        wake_nxt = (|(nmi_req & ~nmi_mask));
        if (!irq_mask && |(irq_req & irq_service_en)) begin
            wake_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= wake_nxt;
        end
    end
endmodule : psc_wake

// ### psc_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// cpu core model: one instruction a cycle
// ----------------------------------------
module psc_cpu_model (
    input  wire logic        core_clk,
    input  wire logic [7:0]  cpu_rdata_r,
    input  wire logic        cpu_rd_valid_r,
    output logic      [31:0] cpu_addr,
    output logic             cpu_wr,
    output logic             cpu_rd,
    output logic             cpu_bit_op,
    output logic      [1:0]  cpu_bit_kind,
    output logic      [2:0]  cpu_bit_sel,
    output logic      [7:0]  cpu_wdata,
    output logic             cpu_instr_done
);
    initial begin
        cpu_addr       = 32'h00000000;
        cpu_wr         = 1'h0;
        cpu_rd         = 1'h0;
        cpu_bit_op     = 1'h0;
        cpu_bit_kind   = 2'h3;
        cpu_bit_sel    = 3'h0;
        cpu_wdata      = 8'h00;
        cpu_instr_done = 1'h0;
    end
    // only core stores, bit ops and reads exist here, there is no dma path
    task automatic issue(input logic [31:0] a, input logic wr,
                         input logic bop, input logic [1:0] k,
                         input logic [2:0] s, input logic [7:0] d);
        @(negedge core_clk);
        cpu_addr       = a;
        cpu_wr         = wr;
        cpu_rd         = 1'h0;
        cpu_bit_op     = bop;
        cpu_bit_kind   = k;
        cpu_bit_sel    = s;
        cpu_wdata      = d;
        cpu_instr_done = 1'h1;
        @(posedge core_clk);
        #1;
    endtask : issue
    // released lines flip, so a stale value cannot pass for a fresh one
    task automatic idle();
        @(negedge core_clk);
        cpu_wr         = 1'h0;
        cpu_rd         = 1'h0;
        cpu_bit_op     = 1'h0;
        cpu_instr_done = 1'h0;
        cpu_addr       = ~cpu_addr;
        cpu_wdata      = ~cpu_wdata;
    endtask : idle
    task automatic read(input logic [31:0] a, output logic v,
                        output logic [7:0] d);
        @(negedge core_clk);
        cpu_wr         = 1'h0;
        cpu_bit_op     = 1'h0;
        cpu_rd         = 1'h1;
        cpu_instr_done = 1'h1;
        cpu_addr       = a;
        @(posedge core_clk);
        #1;
        v = cpu_rd_valid_r;
        d = cpu_rdata_r;
        @(negedge core_clk);
        cpu_rd         = 1'h0;
        cpu_instr_done = 1'h0;
        cpu_addr       = ~cpu_addr;
    endtask : read
    task automatic unlock_then(input logic [7:0] d, input logic bop,
                               input logic [1:0] k, input logic [2:0] s);
        issue(psc_pkg::UNLOCK_ADDR, 1'h1, 1'h0, 2'h3, 3'h0, d);
        issue(psc_pkg::CONTROL_ADDR, 1'h1, bop, k, s, d);
    endtask : unlock_then
endmodule : psc_cpu_model

// ### test_power_save_ctrl_protected.sv
`timescale 1ns/1ps
module test_power_save_ctrl_protected;
    localparam logic [31:0] UNL = psc_pkg::UNLOCK_ADDR;
    localparam logic [31:0] CTL = psc_pkg::CONTROL_ADDR;
    logic        core_clk;
    logic        rst;
    logic [2:0]  nmi;
    logic [63:0] irq;
    logic [63:0] serv;
    logic [31:0] addr;
    logic        wr, rd, bop, done, rdv, inhibit, rejected;
    logic [1:0]  kind;
    logic [2:0]  sel;
    logic [7:0]  wdata, rdata;
    logic        stop, cpu_stop, cg_stop, halt;
    int          n_errors, checks_done;
    psc_ctrl dut (.core_clk(core_clk), .rst(rst), .cpu_addr(addr),
        .cpu_wr(wr), .cpu_rd(rd), .cpu_bit_op(bop), .cpu_bit_kind(kind),
        .cpu_bit_sel(sel), .cpu_wdata(wdata), .cpu_instr_done(done),
        .nmi_pin_0(nmi[0]), .nmi_pin_1(nmi[1]), .nmi_pin_2(nmi[2]),
        .maskable_irq_inputs(irq), .irq_service_en(serv),
        .cpu_rdata_r(rdata), .cpu_rd_valid_r(rdv),
        .irq_ack_inhibit_r(inhibit), .write_rejected_r(rejected),
        .soft_stop_active_r(stop), .cpu_clk_stop_r(cpu_stop),
        .clk_gen_stop_r(cg_stop), .periph_halt_r(halt));
    psc_cpu_model cpu (.core_clk(core_clk), .cpu_rdata_r(rdata),
        .cpu_rd_valid_r(rdv), .cpu_addr(addr), .cpu_wr(wr), .cpu_rd(rd),
        .cpu_bit_op(bop), .cpu_bit_kind(kind), .cpu_bit_sel(sel),
        .cpu_wdata(wdata), .cpu_instr_done(done));
    initial begin
        core_clk = 1'h0;
        forever #20 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // compare and report
    // ----------------------------------------
    task automatic check_byte(string nm, logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : check_byte
    task automatic check_bit(string nm, logic e, logic g);
        checks_done++;
        if (g !== e) begin
            $display("Error %s expected %b seen %b", nm, e, g);
            n_errors++;
        end
    endtask : check_bit
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    task automatic read_ctrl(logic [7:0] e);
        logic       v;
        logic [7:0] d;
        cpu.read(CTL, v, d);
        check_bit("read valid", 1'h1, v);
        check_byte("control", e, d);
    endtask : read_ctrl
    // bounded wait; a hang ends the run with the report
    task automatic wait_stop(logic e, int bound);
        int i;
        i = 0;
        cpu.idle();
        while (stop !== e && i < bound) begin
            @(posedge core_clk);
            #1;
            i++;
        end
        if (stop !== e) begin
            $display("Error stop wait expected %b seen %b", e, stop);
            n_errors++;
            end_sim();
        end
        check_bit("cpu clock stop", e, cpu_stop);
        check_bit("clock gen stop", e, cg_stop);
        check_bit("periph halt", e, halt);
    endtask : wait_stop
    task automatic stays_stopped();
        repeat (10) @(posedge core_clk);
        #1;
        check_bit("still stopped", 1'h1, stop);
    endtask : stays_stopped
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic       v;
        logic [7:0] d;
        read_ctrl(8'h00);
        cpu.read(UNL, v, d);
        check_bit("unlock read valid", 1'h1, v);
        check_bit("stop after reset", 1'h0, stop);
    endtask : t_reset
    task automatic t_protect();
        cpu.issue(CTL, 1'h1, 1'h0, 2'h3, 3'h0, 8'hFF);
        check_bit("rejected unarmed", 1'h1, rejected);
        cpu.issue(UNL, 1'h1, 1'h0, 2'h3, 3'h0, 8'hFD);
        check_bit("inhibit armed", 1'h1, inhibit);
        cpu.issue(CTL, 1'h1, 1'h0, 2'h3, 3'h0, 8'hFD);
        check_bit("accepted", 1'h0, rejected);
        check_bit("inhibit consumed", 1'h0, inhibit);
        cpu.issue(CTL, 1'h1, 1'h0, 2'h3, 3'h0, 8'h00);
        check_bit("second write", 1'h1, rejected);
        cpu.idle();
        read_ctrl(8'hF0);
    endtask : t_protect
    task automatic t_gap();
        cpu.issue(UNL, 1'h1, 1'h0, 2'h3, 3'h0, 8'h00);
        cpu.issue(32'h00000000, 1'h0, 1'h0, 2'h3, 3'h0, 8'h00);
        cpu.issue(CTL, 1'h1, 1'h0, 2'h3, 3'h0, 8'h00);
        check_bit("rejected after gap", 1'h1, rejected);
        cpu.idle();
        read_ctrl(8'hF0);
    endtask : t_gap
    task automatic t_bitops();
        logic [1:0] k [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
        logic [2:0] s [4] = '{3'h7, 3'h7, 3'h4, 3'h6};
        logic [7:0] e [4] = '{8'h70, 8'hF0, 8'hE0, 8'hE0};
        for (int i = 0; i < 4; i++) begin
            cpu.unlock_then(e[i], 1'h1, k[i], s[i]);
            cpu.idle();
            read_ctrl(e[i]);
        end
        cpu.issue(UNL, 1'h1, 1'h1, 2'h0, 3'h0, 8'h00);
        cpu.issue(CTL, 1'h1, 1'h0, 2'h3, 3'h0, 8'h00);
        check_bit("bit op unlock", 1'h1, rejected);
        cpu.idle();
        read_ctrl(8'hE0);
    endtask : t_bitops
    task automatic t_stop_nmi();
        logic [7:0] m;
        for (int i = 0; i < 3; i++) begin
            m = 8'hF0 & ~(8'h20 << i);
            cpu.unlock_then(m, 1'h0, 2'h3, 3'h0);
            cpu.unlock_then(8'hF2, 1'h0, 2'h3, 3'h0);
            wait_stop(1'h1, 4);
            read_ctrl(m | 8'h02);
            repeat (5) cpu.issue(32'h00000000, 1'h0, 1'h0, 2'h3, 3'h0,
                                 8'h00);
            cpu.idle();
            nmi[(i + 1) % 3] = 1'h1;
            stays_stopped();
            @(negedge core_clk);
            nmi = 3'h0;
            nmi[i] = 1'h1;
            wait_stop(1'h0, 20);
            @(negedge core_clk);
            nmi = 3'h0;
            read_ctrl(m);
        end
    endtask : t_stop_nmi
    task automatic t_stop_irq();
        cpu.unlock_then(8'hE0, 1'h0, 2'h3, 3'h0);
        cpu.unlock_then(8'hF2, 1'h0, 2'h3, 3'h0);
        wait_stop(1'h1, 4);
        read_ctrl(8'hE2);
        irq[9] = 1'h1;
        stays_stopped();
        @(negedge core_clk);
        irq = 64'h0000000000000000;
        serv = 64'hFFFFFFFFFFFFFFFF;
        @(negedge core_clk);
        irq[9] = 1'h1;
        wait_stop(1'h0, 20);
        @(negedge core_clk);
        irq = 64'h0000000000000000;
        read_ctrl(8'hE0);
        cpu.unlock_then(8'hF0, 1'h0, 2'h3, 3'h0);
        cpu.unlock_then(8'hF2, 1'h0, 2'h3, 3'h0);
        wait_stop(1'h1, 4);
        irq[63] = 1'h1;
        stays_stopped();
        @(negedge core_clk);
        irq = 64'h0000000000000000;
        rst = 1'h1;
        repeat (2) @(posedge core_clk);
        #1;
        check_bit("stop after reset", 1'h0, stop);
        @(negedge core_clk);
        rst = 1'h0;
        read_ctrl(8'h00);
    endtask : t_stop_irq
    initial begin
        rst = 1'h1;
        nmi = 3'h0;
        irq = 64'h0000000000000000;
        serv = 64'h0000000000000000;
        n_errors = 0;
        checks_done = 0;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'h0;
        t_reset();
        t_protect();
        t_gap();
        t_bitops();
        t_stop_nmi();
        t_stop_irq();
        end_sim();
    end
endmodule : test_power_save_ctrl_protected
